// ### sbp_boot_protocol.sv
/*
 * Target-side serial boot protocol: mode detection from the first byte,
 * RAM transfer password check, flash byte sum and checksum answers.
 * Assumes the serial channel delivers received bytes on clk_sys, the
 * flash answers a byte two edges after its address changes, and the
 * receive pin is asynchronous to clk_sys.
 */
// Summary of operation
// - Timer counts captured on the first four first-byte transitions, reception off.
// - Asynchronous if first interval not longer than third-to-fourth.
// - RAM transfer code 10H is echoed, then the password is checked.
// - Twelve identical non-FFH stored bytes give 11H on the 14th byte, the checksum.
// - Password bytes compared one by one against flash from 474h.
// - Whole flash summed into 16 bits, upper byte sent first.
// - Checksum is the two's complement of the modulo-256 byte sum.
// - Acknowledges keep command nibble; bit 3 receive error (asynchronous mode only), bit 0 error.
// - Asynchronous mode without a usable baud stops silently.
// - Checksum byte answered 10H pass, 11H fail, 18H receive error in asynchronous mode.
`timescale 1ns/1ps
`default_nettype none

module sbp_boot_protocol #(
    parameter int FLASH_BYTES = sbp_pkg::FLASH_BYTES_DEFAULT
)(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Receive pin and serial channel.
    input wire logic rxd_pin,
    input wire sbp_pkg::sbp_rx_type rx,
    input wire logic baud_ok,
    // Transmit stream.
    output sbp_pkg::sbp_byte_type tx,
    input wire logic tx_ready,
    // Flash read port.
    output logic [sbp_pkg::FLASH_AW-1:0] flash_addr,
    input wire logic [7:0] flash_data,
    // Status.
    output logic mode_valid,
    output logic mode_async,
    output logic halted,
    output logic pw_area_error
);
    localparam logic [sbp_pkg::FLASH_AW-1:0] FLASH_LAST =
        sbp_pkg::FLASH_AW'(FLASH_BYTES - 1);

    typedef enum {
        ST_DETECT, ST_DECIDE, ST_HALT, ST_CMD, ST_REPLY,
        ST_PW_AREA, ST_PW_RX, ST_PW_CMP, ST_PW_CHK,
        ST_SUM, ST_SUM_HI, ST_SUM_LO, ST_SUM_CK
    } sbp_state_type;

    sbp_state_type state;
    sbp_state_type ret_state;
    sbp_pkg::sbp_byte_type push;
    logic buf_in_ready;
    logic [sbp_pkg::TIMER_W-1:0] timer;
    logic [sbp_pkg::TIMER_W-1:0] cap [4];
    logic [2:0] edge_cnt;
    logic rxd_s1, rxd_s2, rxd_s3;
    logic rx_edge, pick_async, rx_bad;
    logic [7:0] reply, pw_byte, area_first, csum;
    logic [3:0] cmd_nib, idx;
    logic [1:0] lat;
    logic pw_bad, area_same, rx_err_seen, sum_issue, sum_pipe;
    logic [15:0] sum;

    // Interval between two captured timer counts.
    function automatic logic [sbp_pkg::TIMER_W-1:0] elapsed(
        input logic [sbp_pkg::TIMER_W-1:0] from_cnt,
        input logic [sbp_pkg::TIMER_W-1:0] to_cnt);
        elapsed = to_cnt - from_cnt;
    endfunction : elapsed

    // Two's complement of the modulo-256 sum of two bytes.
    function automatic logic [7:0] neg_sum(input logic [7:0] a,
                                           input logic [7:0] b);
        neg_sum = 8'h00 - 8'(a + b);
    endfunction : neg_sum

    assign rx_edge = rxd_s2 ^ rxd_s3;
    assign pick_async = elapsed(cap[0], cap[1]) <=
                        elapsed(cap[2], cap[3]);
    assign rx_bad = rx.error && mode_async;

    // Free-running edge timer; 24 bits cover over half a second.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            timer <= '0;
        else
            timer <= timer + 1'b1;
    end

    // Two-stage synchroniser plus an edge-detect stage on the pin.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_s3 <= 1'b1;
        end
        else
        begin
            rxd_s1 <= rxd_pin;
            rxd_s2 <= rxd_s1;
            rxd_s3 <= rxd_s2;
        end
    end

    // Captures the timer at each of the first four pin transitions.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            edge_cnt <= '0;
            for (int i = 0; i < 4; i++)
                cap[i] <= '0;
        end
        else if (state == ST_DETECT && rx_edge &&
                 edge_cnt < sbp_pkg::EDGES_NEEDED)
        begin
            cap[edge_cnt[1:0]] <= timer;
            edge_cnt <= edge_cnt + 3'h1;
        end
    end

    // Protocol sequencer; every answer leaves through ST_REPLY.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_DETECT;
            ret_state <= ST_CMD;
            push <= '0;
            reply <= '0;
            mode_valid <= 1'b0;
            mode_async <= 1'b0;
            halted <= 1'b0;
            pw_area_error <= 1'b0;
            flash_addr <= '0;
            cmd_nib <= sbp_pkg::NIB_RESET;
            idx <= '0;
            lat <= '0;
            pw_byte <= '0;
            area_first <= '0;
            area_same <= 1'b0;
            pw_bad <= 1'b0;
            rx_err_seen <= 1'b0;
            csum <= '0;
            sum <= '0;
            sum_issue <= 1'b0;
            sum_pipe <= 1'b0;
        end
        else
        begin
            if (buf_in_ready)
                push.valid <= 1'b0;
            case (state)
                ST_DETECT:
                    if (edge_cnt == sbp_pkg::EDGES_NEEDED)
                        state <= ST_DECIDE;
                ST_DECIDE:
                begin
                    mode_valid <= 1'b1;
                    mode_async <= pick_async;
                    if (pick_async && !baud_ok)
                    begin
                        halted <= 1'b1;
                        state <= ST_HALT;
                    end
                    else
                    begin
                        reply <= pick_async ? sbp_pkg::CODE_ASYNC
                                            : sbp_pkg::CODE_CLOCKED;
                        ret_state <= ST_CMD;
                        state <= ST_REPLY;
                    end
                end
                ST_HALT:
                    state <= ST_HALT;
                ST_REPLY:
                    if (!push.valid || buf_in_ready)
                    begin
                        push.valid <= 1'b1;
                        push.data <= reply;
                        state <= ret_state;
                    end
                ST_CMD:
                    if (rx.valid)
                    begin
                        ret_state <= ST_CMD;
                        state <= ST_REPLY;
                        if (rx_bad)
                            reply <= {cmd_nib, sbp_pkg::FLAG_RX_ERR};
                        else
                        begin
                            case (rx.data)
                                sbp_pkg::CMD_RAM:
                                begin
                                    reply <= rx.data;
                                    cmd_nib <= rx.data[7:4];
                                    ret_state <= ST_PW_AREA;
                                    idx <= '0;
                                    lat <= '0;
                                    area_same <= 1'b1;
                                    pw_bad <= 1'b0;
                                    rx_err_seen <= 1'b0;
                                    csum <= '0;
                                end
                                sbp_pkg::CMD_SUM:
                                begin
                                    reply <= rx.data;
                                    cmd_nib <= rx.data[7:4];
                                    ret_state <= ST_SUM;
                                    flash_addr <= '0;
                                    sum <= '0;
                                    sum_issue <= 1'b1;
                                    sum_pipe <= 1'b0;
                                end
                                sbp_pkg::CMD_INFO:
                                begin
                                    reply <= rx.data;
                                    cmd_nib <= rx.data[7:4];
                                end
                                default:
                                    reply <= {cmd_nib,
                                              sbp_pkg::FLAG_BAD_CMD};
                            endcase
                        end
                    end
                ST_PW_AREA:
                begin
                    flash_addr <= sbp_pkg::PW_BASE + {15'h0000, idx};
                    lat <= lat + 2'h1;
                    if (lat == sbp_pkg::FLASH_LAT)
                    begin
                        lat <= '0;
                        idx <= idx + 4'h1;
                        if (idx == 4'h0)
                            area_first <= flash_data;
                        else if (flash_data != area_first)
                            area_same <= 1'b0;
                        if (idx == sbp_pkg::PW_LEN - 4'h1)
                        begin
                            pw_area_error <= area_same &&
                                (flash_data == area_first) &&
                                (area_first != sbp_pkg::BYTE_ERASED);
                            idx <= '0;
                            state <= ST_PW_RX;
                        end
                    end
                end
                ST_PW_RX:
                    if (rx.valid)
                    begin
                        pw_byte <= rx.data;
                        csum <= 8'(csum + rx.data);
                        if (rx_bad)
                            rx_err_seen <= 1'b1;
                        flash_addr <= sbp_pkg::PW_BASE + {15'h0000, idx};
                        lat <= '0;
                        state <= ST_PW_CMP;
                    end
                ST_PW_CMP:
                begin
                    lat <= lat + 2'h1;
                    if (lat == sbp_pkg::FLASH_LAT - 2'h1)
                    begin
                        if (flash_data != pw_byte)
                            pw_bad <= 1'b1;
                        idx <= idx + 4'h1;
                        state <= (idx == sbp_pkg::PW_LEN - 4'h1)
                                 ? ST_PW_CHK : ST_PW_RX;
                    end
                end
                ST_PW_CHK:
                    if (rx.valid)
                    begin
                        ret_state <= ST_CMD;
                        state <= ST_REPLY;
                        if (rx_bad || rx_err_seen)
                            reply <= sbp_pkg::ACK_RX_ERR;
                        else if (neg_sum(csum, rx.data) != 8'h00 ||
                                 pw_bad || pw_area_error)
                            reply <= sbp_pkg::ACK_FAIL;
                        else
                            reply <= sbp_pkg::ACK_PASS;
                    end
                ST_SUM:
                begin
                    if (sum_issue)
                    begin
                        if (flash_addr == FLASH_LAST)
                            sum_issue <= 1'b0;
                        else
                            flash_addr <= flash_addr + 1'b1;
                    end
                    sum_pipe <= sum_issue;
                    if (sum_pipe)
                        sum <= sum + {8'h00, flash_data};
                    if (!sum_issue && !sum_pipe)
                        state <= ST_SUM_HI;
                end
                ST_SUM_HI:
                begin
                    reply <= sum[15:8];
                    ret_state <= ST_SUM_LO;
                    state <= ST_REPLY;
                end
                ST_SUM_LO:
                begin
                    reply <= sum[7:0];
                    ret_state <= ST_SUM_CK;
                    state <= ST_REPLY;
                end
                ST_SUM_CK:
                begin
                    reply <= neg_sum(sum[15:8], sum[7:0]);
                    ret_state <= ST_CMD;
                    state <= ST_REPLY;
                end
                default:
                    state <= ST_DETECT;
            endcase
        end
    end

    // Buffer so a stalled receiver loses no answer byte.
    sbp_tx_buffer #(
        .WIDTH(8)
    ) u_tx_buffer (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(push.valid),
        .in_data(push.data),
        .in_ready(buf_in_ready),
        .out_valid(tx.valid),
        .out_data(tx.data),
        .out_ready(tx_ready)
    );

    // Checks tying outputs and state to their causes.
    a_timer_free_run: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reset) |-> timer == $past(timer) + 1'b1)
        else $error("edge timer did not advance");
    a_edge_capture_count: assert property (@(posedge clk_sys)
        disable iff (reset)
        state == ST_DETECT && rx_edge && edge_cnt < 3'h4
        |=> edge_cnt == $past(edge_cnt) + 3'h1)
        else $error("edge not captured");
    a_mode_pick_rule: assert property (@(posedge clk_sys) disable iff (reset)
        state == ST_DECIDE |=> mode_valid && mode_async == $past(pick_async))
        else $error("mode decision wrong");
    a_halt_stays_silent: assert property (@(posedge clk_sys)
        disable iff (reset)
        halted |-> !push.valid && state == ST_HALT)
        else $error("reply after halt");
    a_ram_cmd_echo: assert property (@(posedge clk_sys) disable iff (reset)
        state == ST_CMD && rx.valid && !rx_bad && rx.data == 8'h10
        |=> state == ST_REPLY && reply == 8'h10 && ret_state == ST_PW_AREA)
        else $error("RAM command not echoed");
    a_area_error_ack: assert property (@(posedge clk_sys) disable iff (reset)
        state == ST_PW_CHK && rx.valid && pw_area_error && !rx_bad &&
        !rx_err_seen |=> reply == 8'h11 ##1 push.valid && push.data == 8'h11)
        else $error("area error not answered 11H");
    a_pw_mismatch_flag: assert property (@(posedge clk_sys)
        disable iff (reset)
        state == ST_PW_CMP && lat == 2'h1 && flash_data != pw_byte
        |=> pw_bad)
        else $error("password mismatch missed");
    a_sum_high_first: assert property (@(posedge clk_sys) disable iff (reset)
        state == ST_SUM_LO |-> $past(reply) == sum[15:8]
        ##1 reply == sum[7:0])
        else $error("sum byte order wrong");
    a_sum_checksum: assert property (@(posedge clk_sys) disable iff (reset)
        state == ST_SUM_CK |=> 8'(reply + sum[15:8] + sum[7:0]) == 8'h00)
        else $error("checksum byte wrong");
    a_cmd_rx_error_ack: assert property (@(posedge clk_sys)
        disable iff (reset)
        state == ST_CMD && rx.valid && rx_bad
        |=> reply == {cmd_nib, 4'h8})
        else $error("receive error ack wrong");
    a_chk_rx_error_ack: assert property (@(posedge clk_sys)
        disable iff (reset)
        state == ST_PW_CHK && rx.valid && rx_bad |=> reply == 8'h18)
        else $error("checksum receive error ack wrong");
endmodule : sbp_boot_protocol

`default_nettype wire

// ### sbp_boot_protocol_tb.sv
/*
 * Self-checking bench for the serial boot protocol block.
 * Assumes the host model stands in for the flash, pin and receiver.
 */
`timescale 1ns/1ps
`default_nettype none

module sbp_boot_protocol_tb;
    logic clk_sys, reset, rxd_pin, baud_ok, tx_ready, stall;
    logic mode_valid, mode_async, halted, pw_area_error;
    logic [7:0] flash_data, pw_fill;
    logic [sbp_pkg::FLASH_AW-1:0] flash_addr;
    sbp_pkg::sbp_rx_type rx;
    sbp_pkg::sbp_byte_type tx;
    logic [7:0] got[$];
    int n_mismatch = 0;
    int check_count = 0;

    sbp_boot_protocol #(.FLASH_BYTES(4)) u_sbp_boot_protocol (
        .clk_sys(clk_sys), .reset(reset), .rxd_pin(rxd_pin), .rx(rx),
        .baud_ok(baud_ok), .tx(tx), .tx_ready(tx_ready),
        .flash_addr(flash_addr), .flash_data(flash_data),
        .mode_valid(mode_valid), .mode_async(mode_async),
        .halted(halted), .pw_area_error(pw_area_error));

    sbp_host_model u_sbp_host_model (
        .clk_sys(clk_sys), .reset(reset), .flash_addr(flash_addr),
        .flash_data(flash_data), .rxd_pin(rxd_pin),
        .tx_ready(tx_ready), .stall(stall), .pw_fill(pw_fill));

    // Records every byte the receiver takes.
    always @(posedge clk_sys)
        if (tx.valid && tx_ready)
            got.push_back(tx.data);

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // Waits a bounded time for the next answer byte and compares it.
    task automatic take(input logic [7:0] exp);
        int n;
        for (n = 0; n < 400 && got.size() == 0; n++)
            tick(1);
        check("tx byte", got.size() > 0 ? got.pop_front() : 8'hxx, exp);
    endtask : take

    task automatic send_rx(input logic [7:0] d, input logic err);
        rx = '{1'b1, err, d};
        tick(1);
        rx.valid = 1'b0;
        tick(10);
    endtask : send_rx

    // Resets, checks idle outputs, then sends the mode byte.
    task automatic start(input logic [7:0] b, input logic ok);
        reset = 1'b1;
        tick(5);
        check("reset outs", 8'({mode_valid, halted, tx.valid}), 8'h00);
        got.delete();
        reset = 1'b0;
        baud_ok = ok;
        u_sbp_host_model.send_byte(b);
        tick(20);
    endtask : start

    // Mode byte timing picks the link mode, echoed or silent.
    task automatic t_mode();
        start(sbp_pkg::CODE_CLOCKED, 1'b1);
        check("mode", 8'({mode_valid, mode_async}), 8'h02);
        take(sbp_pkg::CODE_CLOCKED);
        send_rx(sbp_pkg::CMD_INFO, 1'b1);
        take(sbp_pkg::CMD_INFO);
        start(sbp_pkg::CODE_ASYNC, 1'b0);
        check("halt", 8'({mode_valid, halted}), 8'h03);
        send_rx(sbp_pkg::CMD_INFO, 1'b0);
        check("silent", 8'(got.size()), 8'h00);
        start(sbp_pkg::CODE_ASYNC, 1'b1);
        check("mode", 8'({mode_valid, mode_async, halted}), 8'h06);
        take(sbp_pkg::CODE_ASYNC);
    endtask : t_mode

    // Error acknowledges keep the previous command nibble.
    task automatic t_cmds();
        send_rx(8'h55, 1'b0);
        take(8'h01);
        send_rx(sbp_pkg::CMD_SUM, 1'b1);
        take(8'h08);
        send_rx(sbp_pkg::CMD_INFO, 1'b0);
        take(sbp_pkg::CMD_INFO);
        send_rx(8'h7e, 1'b0);
        take(8'h31);
    endtask : t_cmds

    // Flash sum of A1 B2 C3 D4 with a stalling receiver.
    task automatic t_sum();
        stall = 1'b1;
        send_rx(sbp_pkg::CMD_SUM, 1'b0);
        take(sbp_pkg::CMD_SUM);
        take(8'h02);
        take(8'hea);
        take(8'h14);
        stall = 1'b0;
        tick(5);
    endtask : t_sum

    // One RAM transfer; bad 0..11 spoils a password byte, 12 the sum.
    // A receive error is flagged on byte err_at, 12 being the sum byte.
    task automatic ram(input logic [7:0] fill, input int bad,
        input int err_at, input logic [7:0] exp);
        logic [7:0] sum, b;
        int i;
        pw_fill = fill;
        sum = 8'h00;
        send_rx(sbp_pkg::CMD_RAM, 1'b0);
        take(sbp_pkg::CMD_RAM);
        tick(60);
        for (i = 0; i < 12; i++)
        begin
            b = (fill != 8'h00) ? fill : 8'hb4 + 8'(i);
            b = b ^ {7'h0, i == bad};
            sum = sum + b;
            send_rx(b, i == err_at);
        end
        send_rx((8'h00 - sum) ^ {7'h0, bad == 12}, err_at == 12);
        take(exp);
    endtask : ram

    task automatic t_ram();
        ram(8'h00, 99, 99, sbp_pkg::ACK_PASS);
        ram(8'h00, 11, 99, sbp_pkg::ACK_FAIL);
        ram(8'h00, 0, 99, sbp_pkg::ACK_FAIL);
        ram(8'h00, 12, 99, sbp_pkg::ACK_FAIL);
        ram(8'h00, 99, 3, sbp_pkg::ACK_RX_ERR);
        ram(8'h00, 99, 12, sbp_pkg::ACK_RX_ERR);
        ram(8'h5a, 99, 99, sbp_pkg::ACK_FAIL);
        check("area err", 8'(pw_area_error), 8'h01);
        ram(8'hff, 99, 99, sbp_pkg::ACK_PASS);
        check("area err", 8'(pw_area_error), 8'h00);
    endtask : t_ram

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // System clock at 25 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Cuts a hung run short.
    initial
    begin
        #400000;
        n_mismatch++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial
    begin
        reset = 1'b1;
        rx = '0;
        baud_ok = 1'b1;
        stall = 1'b0;
        pw_fill = 8'h00;
        t_mode();
        t_cmds();
        t_sum();
        t_ram();
        end_of_test();
    end
endmodule : sbp_boot_protocol_tb

`default_nettype wire

// ### sbp_host_model.sv
/*
 * Controller and flash model facing the serial boot protocol block.
 * Assumes clk_sys times the flash and the receiver's stall pattern.
 */
`timescale 1ns/1ps
`default_nettype none

module sbp_host_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Flash side.
    input wire logic [sbp_pkg::FLASH_AW-1:0] flash_addr,
    output logic [7:0] flash_data,
    // Link side.
    output logic rxd_pin,
    output logic tx_ready,
    // Set-up from the bench.
    input wire logic stall,
    input wire logic [7:0] pw_fill
);
    logic [1:0] beat;

    // Sum area bytes, then the password area, else zero.
    function automatic logic [7:0] peek(input logic [18:0] a);
        if (a < 19'h4)
            return 8'ha1 + 8'h11 * a[7:0];
        if (a >= 19'h474 && a <= 19'h47f)
            return (pw_fill != 8'h00) ? pw_fill : 8'h40 + a[7:0];
        return 8'h00;
    endfunction : peek

    // Flash takes the address at the next edge; data serves the edge after.
    always_ff @(posedge clk_sys)
    begin
        flash_data <= peek(flash_addr);
    end

    // Receiver stalls three of every four cycles when asked to.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            beat <= 2'h0;
        else
            beat <= beat + 2'h1;
    end
    assign tx_ready = !stall || beat == 2'h0;

    // Pin idles high between frames.
    initial rxd_pin = 1'b1;

    // Sends one framed byte, low start bit, LSB first, off-phase.
    task automatic send_byte(input logic [7:0] b);
        int i;
        @(posedge clk_sys);
        #1;
        for (i = 0; i < 10; i++)
        begin
            rxd_pin = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            #320;
        end
    endtask : send_byte
endmodule : sbp_host_model

`default_nettype wire

// ### sbp_pkg.sv
/*
 * Shared constants and carrier types for the serial boot protocol block.
 * Assumes a single 25 MHz system clock domain and a byte-wide flash port.
 */
`default_nettype none

package sbp_pkg;
    // Widths of the edge timer and the flash byte address.
    localparam int TIMER_W = 24;
    localparam int FLASH_AW = 19;
    localparam int FLASH_BYTES_DEFAULT = 524288;

    // Mode selection bytes and their echoes.
    localparam logic [7:0] CODE_ASYNC = 8'h86;
    localparam logic [7:0] CODE_CLOCKED = 8'h30;

    // Command codes.
    localparam logic [7:0] CMD_RAM = 8'h10;
    localparam logic [7:0] CMD_SUM = 8'h20;
    localparam logic [7:0] CMD_INFO = 8'h30;

    // Checksum byte answers and acknowledge flag nibbles.
    localparam logic [7:0] ACK_PASS = 8'h10;
    localparam logic [7:0] ACK_FAIL = 8'h11;
    localparam logic [7:0] ACK_RX_ERR = 8'h18;
    localparam logic [3:0] FLAG_RX_ERR = 4'h8;
    localparam logic [3:0] FLAG_BAD_CMD = 4'h1;
    localparam logic [3:0] NIB_RESET = 4'h0;

    // Password area location, length and the erased byte value.
    localparam logic [18:0] PW_BASE = 19'h00474;
    localparam logic [3:0] PW_LEN = 4'hc;
    localparam logic [7:0] BYTE_ERASED = 8'hff;

    // Edge captures needed for the mode decision.
    localparam logic [2:0] EDGES_NEEDED = 3'h4;

    // Edges from a flash address update to valid read data.
    localparam logic [1:0] FLASH_LAT = 2'h2;

    // Received byte from the serial channel.
    typedef struct packed {
        logic valid;
        logic error;
        logic [7:0] data;
    } sbp_rx_type;

    // Transmit byte with its valid flag.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sbp_byte_type;
endpackage : sbp_pkg

`default_nettype wire

// ### sbp_tx_buffer.sv
/*
 * Two-entry transmit buffer with valid and ready on both sides.
 * Assumes both sides run on clk_sys; all outputs come from flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none

module sbp_tx_buffer #(
    parameter int WIDTH = 8
)(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic [WIDTH-1:0] spare;

    // The output stage refills from the spare first, so order is kept.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
            spare <= '0;
            in_ready <= 1'b1;
        end
        else if (!out_valid || out_ready)
        begin
            if (!in_ready)
            begin
                out_data <= spare;
                out_valid <= 1'b1;
                in_ready <= 1'b1;
            end
            else if (in_valid)
            begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end
            else
            begin
                out_valid <= 1'b0;
            end
        end
        else if (in_valid && in_ready)
        begin
            spare <= in_data;
            in_ready <= 1'b0;
        end
    end
endmodule : sbp_tx_buffer

`default_nettype wire
